// *** tb/d2rp_link_props.sv ***
// d2rp_link_props: command spacing and data timing checks on the link wires
// assumes it watches one d2rp_link_if whose ck comes from the controller
`timescale 1ns/1ps
module d2rp_link_props
  import d2rp_pkg::*;
(
  input wire logic                        rst_n,
  input wire logic                        ck,
  input wire d2rp_pkg::d2rp_cmd_type      cmd,
  input wire logic [d2rp_pkg::BANK_W-1:0] bank,
  input wire logic                        auto_precharge_select_bit,
  input wire logic                        dq_c_oe,
  input wire logic                        dq_d_oe,
  input wire logic                        strobe_d_oe
);
  import d2rp_pkg::*;
  localparam int RL_LO = RD_LAT;
  localparam int RL_HI = RD_LAT + 1;
  localparam int WL_LO = WR_LAT;
  localparam int WL_HI = WR_LAT + 1;
  logic [BANK_W-1:0] rd_bank;
  logic [BANK_W-1:0] act_bank;
  logic              rd_ap;
  logic [CNT_W-1:0]  rd_age;
  logic [CNT_W-1:0]  act_age;
  wire               is_rd  = (cmd == D2RP_RD);
  wire               is_wr  = (cmd == D2RP_WR);
  wire               is_act = (cmd == D2RP_ACT);
  wire               is_pre = (cmd == D2RP_PRE);
  // ages saturate so an idle bank never looks freshly used
  wire [CNT_W-1:0]   next_rd_age  = is_rd ? 8'h01 : ((rd_age == CNT_MAX) ? rd_age : rd_age + 8'h01);
  wire [CNT_W-1:0]   next_act_age = is_act ? 8'h01 : ((act_age == CNT_MAX) ? act_age : act_age + 8'h01);
  wire               next_rd_ap   = is_rd ? auto_precharge_select_bit : ((is_act && bank == rd_bank) ? 1'b0 : rd_ap);
  always_ff @(posedge ck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_bank  <= '0;
      act_bank <= '0;
      rd_ap    <= 1'b0;
      rd_age   <= CNT_MAX;
      act_age  <= CNT_MAX;
    end
    else
    begin
      rd_bank  <= is_rd ? bank : rd_bank;
      act_bank <= is_act ? bank : act_bank;
      rd_ap    <= next_rd_ap;
      rd_age   <= next_rd_age;
      act_age  <= next_act_age;
    end
  end
  a_read_latency: assert property (@(posedge ck) disable iff (!rst_n)
    is_rd |-> ##[RL_LO:RL_HI] dq_d_oe) else $error("read data not driven in time");
  a_write_latency: assert property (@(posedge ck) disable iff (!rst_n)
    is_wr |-> ##[WL_LO:WL_HI] dq_c_oe) else $error("write data not driven in time");
  a_strobe_with_data: assert property (@(posedge ck) disable iff (!rst_n)
    dq_d_oe |-> strobe_d_oe && !dq_c_oe) else $error("read data without strobes");
  a_pre_spacing: assert property (@(posedge ck) disable iff (!rst_n)
    is_pre && bank == rd_bank |-> rd_age >= RD2PRE) else $error("precharge too soon after read");
  a_pre_not_ap: assert property (@(posedge ck) disable iff (!rst_n)
    is_pre && bank == rd_bank |-> !rd_ap) else $error("precharge after auto precharge read");
  a_pre_row_active: assert property (@(posedge ck) disable iff (!rst_n)
    is_pre && bank == act_bank |-> act_age >= RAS_CK) else $error("precharge before row active time");
  a_act_after_ap: assert property (@(posedge ck) disable iff (!rst_n)
    is_act && bank == rd_bank && rd_ap |-> rd_age >= RDA2ACT) else $error("activate too soon after read ap");
  a_other_bank_rd: assert property (@(posedge ck) disable iff (!rst_n)
    is_rd && bank != rd_bank && rd_ap |-> rd_age >= CC_RD) else $error("read too close to read ap");
  a_other_bank_wr: assert property (@(posedge ck) disable iff (!rst_n)
    is_wr && bank != rd_bank && rd_ap |-> rd_age >= CC_WR) else $error("write too close to read ap");
endmodule

// *** tb/ddr2_read_precharge_timing_test.sv ***
// ddr2_read_precharge_timing_test: controller and device joined by one link
// assumes the device starts empty, so every bank is written before it is read
`timescale 1ns/1ps
module ddr2_read_precharge_timing_test;
  import d2rp_pkg::*;
  logic              clk_sys;
  logic              rst_n;
  logic              req_valid;
  d2rp_cmd_type      req_cmd;
  logic [BANK_W-1:0] req_bank;
  logic [COL_W-1:0]  req_col;
  logic              req_ap;
  logic [DQ_W-1:0]   req_wdata;
  logic              req_taken;
  logic              rd_valid;
  logic [DQ_W-1:0]   rd_data;
  logic [BANKS-1:0]  bank_open;
  logic              int_precharge;
  logic [DQ_W-1:0]   mem [BANKS];
  logic [DQ_W-1:0]   exp_q [$];
  logic [31:0]       lfsr;
  int                num_errors;
  int                num_checks;
  int                cycles;
  d2rp_link_if link ();
  d2rp_ctrl u_d2rp_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_col(req_col), .req_ap(req_ap), .req_wdata(req_wdata),
    .req_taken(req_taken), .rd_valid(rd_valid), .rd_data(rd_data));
  d2rp_dev u_d2rp_dev (.rst_n(rst_n), .link(link), .bank_open(bank_open), .int_precharge(int_precharge));
  d2rp_link_props u_d2rp_link_props (.rst_n(rst_n), .ck(link.ck), .cmd(link.cmd), .bank(link.bank),
    .auto_precharge_select_bit(link.auto_precharge_select_bit), .dq_c_oe(link.dq_c_oe),
    .dq_d_oe(link.dq_d_oe), .strobe_d_oe(link.strobe_d_oe));
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // valid stays up between requests; rest drops it
  task automatic issue(input d2rp_cmd_type c, input logic [BANK_W-1:0] b, input logic [COL_W-1:0] a,
                       input logic ap, input logic [DQ_W-1:0] w);
    int n;
    req_cmd = c;
    req_bank = b;
    req_col = a;
    req_ap = ap;
    req_wdata = w;
    req_valid = 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (req_taken !== 1'b1 && n < 200);
    check({15'h0, req_taken}, 16'h0001);
    if (c == D2RP_WR)
      mem[b] = w;
    if (c == D2RP_RD)
    begin
      exp_q.push_back(mem[b] ^ DQ_W'(a));
      exp_q.push_back((mem[b] ^ DQ_W'(a)) + 16'h0001);
    end
  endtask
  task automatic rest(input int n);
    req_valid = 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_ap(input logic [BANK_W-1:0] b);
    int n;
    n = 0;
    while (int_precharge !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    // the pulse rises on the firing edge itself, which may be postponed, so this bound is a floor only
    check({15'h0, n >= 2 * AP_EDGE && n < 100}, 16'h0001);
    rest(4);
    check({15'h0, bank_open[b]}, 16'h0000);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  always @(posedge clk_sys)
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(16'h0000, 16'h0001);
      else
        check(rd_data, exp_q.pop_front());
    end
  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = D2RP_NOP;
    req_bank = '0;
    req_col = '0;
    req_ap = 1'b0;
    req_wdata = '0;
    lfsr = 32'h2F9D;
    num_errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    rest(2);
    for (int i = 0; i < BANKS; i++)
    begin
      lfsr = lfsr_next(lfsr);
      issue(D2RP_ACT, BANK_W'(i), '0, 1'b0, '0);
      issue(D2RP_WR, BANK_W'(i), lfsr[9:0], 1'b0, lfsr[31:16]);
      issue(D2RP_RD, BANK_W'(i), lfsr[19:10], 1'b0, '0);
      issue(D2RP_PRE, BANK_W'(i), '0, 1'b0, '0);
    end
    rest(20);
    $display("test write_read done");
    issue(D2RP_ACT, 3'h3, '0, 1'b0, '0);
    issue(D2RP_WR, 3'h3, 10'h005, 1'b0, 16'hA5C3);
    issue(D2RP_RD, 3'h3, 10'h3FF, 1'b1, '0);
    wait_ap(3'h3);
    issue(D2RP_ACT, 3'h3, '0, 1'b0, '0);
    issue(D2RP_PRE, 3'h3, '0, 1'b0, '0);
    rest(20);
    $display("test read_auto_precharge done");
    issue(D2RP_ACT, 3'h1, '0, 1'b0, '0);
    issue(D2RP_ACT, 3'h2, '0, 1'b0, '0);
    issue(D2RP_WR, 3'h1, 10'h011, 1'b0, 16'h1234);
    issue(D2RP_WR, 3'h2, 10'h022, 1'b0, 16'hBEEF);
    issue(D2RP_RD, 3'h1, 10'h100, 1'b1, '0);
    issue(D2RP_RD, 3'h2, 10'h200, 1'b0, '0);
    rest(30);
    check({15'h0, bank_open[1]}, 16'h0000);
    check({15'h0, bank_open[2]}, 16'h0001);
    $display("test concurrent_read done");
    issue(D2RP_ACT, 3'h5, '0, 1'b0, '0);
    issue(D2RP_WR, 3'h5, 10'h055, 1'b1, lfsr[15:0]);
    wait_ap(3'h5);
    issue(D2RP_ACT, 3'h5, '0, 1'b0, '0);
    issue(D2RP_RD, 3'h5, 10'h0F0, 1'b1, '0);
    issue(D2RP_WR, 3'h2, 10'h033, 1'b0, 16'h0F0F);
    issue(D2RP_PRE, 3'h2, '0, 1'b0, '0);
    rest(30);
    check({15'h0, bank_open[5]}, 16'h0000);
    check({15'h0, bank_open[2]}, 16'h0000);
    $display("test write_auto_precharge done");
    rest(40);
    check(16'(exp_q.size()), 16'h0000);
    print_verdict();
  end
endmodule

// *** verilog/d2rp_ctrl.sv ***
// d2rp_ctrl: memory controller end; gates user commands against per-bank timing
// assumes clk_sys at 125 MHz; the link clock is clk_sys divided by two
//
// Contract
// - explicit precharge only after non-auto-precharge read
// - read-to-precharge meets AL+BL/2 and read_to_precharge_time
// - read_to_precharge_time counts from final prefetch edge
// - no same-bank command inside precharge_period
// - read-to-precharge = AL+BL/2-2+max(rtp,2)
// - auto_precharge_select_bit high selects read auto-precharge
// - device auto-precharges at AL+BL/2 if timing met
// - device postpones auto precharge until ras and rtp met
// - precharge period starts at internal precharge moment
// - read-ap to activate waits AL+ceil(rtp+rp), BL8 +2
// - round (rtp+rp)/ck up to whole clocks
// - internal precharge not before final prefetch plus two
// - device accepts read-ap while other banks operate
// - other-bank spacing after read-ap: BL/2, BL/2+2, 1
// - explicit precharge also waits row_active_time
// - lower strobe times low byte, upper high byte
// - write_latency equals read_latency minus one
// - write carries bank, column and auto-precharge choice
// - read_latency equals additive plus column-access latency
`timescale 1ns/1ps
module d2rp_ctrl
  import d2rp_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  d2rp_link_if.ctrl              link,
  input  wire logic              req_valid,
  input  wire d2rp_pkg::d2rp_cmd_type req_cmd,
  input  wire logic [d2rp_pkg::BANK_W-1:0] req_bank,
  input  wire logic [d2rp_pkg::COL_W-1:0]  req_col,
  input  wire logic              req_ap,
  input  wire logic [d2rp_pkg::DQ_W-1:0]   req_wdata,
  output logic                   req_taken,
  output logic                   rd_valid,
  output logic [d2rp_pkg::DQ_W-1:0]        rd_data
);
  import d2rp_pkg::*;

  // wait, in ck, before a bank may reopen after auto precharge: the device's firing edge plus precharge_period
  // limitation: assumes row_active_time is already met at that firing edge
  localparam logic [CNT_W-1:0] RDA_WAIT = ((AP_EDGE > RTP_DONE) ? AP_EDGE : RTP_DONE) + RP_CK - 8'h01;
  localparam logic [CNT_W-1:0] WRA_WAIT = CNT_W'(WR_LAT + HALF_BL) + RP_CK;

  logic              ck_q;
  d2rp_cmd_type      cmd_q;
  logic [BANK_W-1:0] bank_q;
  logic [COL_W-1:0]  col_q;
  logic              ap_q;
  logic [BANKS-1:0]  open;
  logic [BANKS-1:0]  ap_pend;
  logic [CNT_W-1:0]  ras_cnt [BANKS];
  logic [CNT_W-1:0]  rd_cnt [BANKS];
  logic [CNT_W-1:0]  rp_cnt [BANKS];
  logic [CNT_W-1:0]  cc_cnt;
  logic [BANK_W-1:0] cc_bank;
  logic              cc_live;
  logic [WR_LAT-1:0] wr_sr;
  logic [CNT_W-1:0]  wr_beats;
  logic [DQ_W-1:0]   wd;
  logic              wd_oe;
  logic [DQ_W-1:0]   dq_s1;
  logic [DQ_W-1:0]   dq_s2;
  logic              stb_s1;
  logic              stb_s2;
  logic              oe_dly1;
  logic              oe_dly2;

  // commands change on the falling edge of ck so the device samples them stable on the next rise
  wire tick = ck_q;
  wire [CNT_W-1:0] ras_b = ras_cnt[req_bank];
  wire [CNT_W-1:0] rd_b  = rd_cnt[req_bank];
  wire [CNT_W-1:0] rp_b  = rp_cnt[req_bank];
  wire             open_b = open[req_bank];
  wire             apw_b  = ap_pend[req_bank];
  wire cc_other = cc_live && (cc_bank != req_bank);
  wire cc_rd_ok = !cc_other || (cc_cnt >= CC_RD);
  wire cc_wr_ok = !cc_other || (cc_cnt >= CC_WR);
  wire cc_pa_ok = !cc_other || (cc_cnt >= CC_PA);
  wire rp_ok    = (rp_b == '0);
  wire act_ok   = !open_b && rp_ok && cc_pa_ok
                  && (!apw_b || (rd_b >= RDA2ACT));
  wire rw_ok    = open_b && rp_ok && !apw_b;
  wire pre_ok   = open_b && !apw_b && rp_ok && cc_pa_ok
                  && (rd_b >= RD2PRE) && (ras_b >= RAS_CK);
  wire wr_busy  = (wr_sr != '0) || (wr_beats != '0);
  logic legal;
  always_comb
  begin
    case (req_cmd)
      D2RP_ACT: legal = act_ok;
      D2RP_RD:  legal = rw_ok && cc_rd_ok;
      D2RP_WR:  legal = rw_ok && cc_wr_ok && !wr_busy;
      D2RP_PRE: legal = pre_ok;
      default:  legal = 1'b0;
    endcase
  end
  wire issue  = tick && req_valid && legal && !req_taken;
  wire is_rd  = issue && (req_cmd == D2RP_RD);
  wire is_wr  = issue && (req_cmd == D2RP_WR);
  wire is_act = issue && (req_cmd == D2RP_ACT);
  wire is_pre = issue && (req_cmd == D2RP_PRE);
  wire is_rda = is_rd && req_ap;
  wire is_wra = is_wr && req_ap;
  wire wr_start = tick && wr_sr[WR_LAT-1];

  // link clock divider: the controller owns the link clock
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n) ck_q <= 1'b0;
    else        ck_q <= ~ck_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_q     <= D2RP_NOP;
      bank_q    <= '0;
      col_q     <= '0;
      ap_q      <= 1'b0;
      req_taken <= 1'b0;
    end
    else if (tick)
    begin
      cmd_q     <= issue ? req_cmd : D2RP_NOP;
      bank_q    <= req_bank;
      col_q     <= req_col;
      ap_q      <= issue && req_ap;
      req_taken <= issue;
    end
    else
    begin
      req_taken <= 1'b0;
    end
  end

  // per-bank bookkeeping; counters saturate so an idle bank stays permitted
  genvar b;
  generate
    for (b = 0; b < BANKS; b++)
    begin : g_bank
      wire hit = (req_bank == BANK_W'(b));
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          open[b]    <= 1'b0;
          ap_pend[b] <= 1'b0;
          ras_cnt[b] <= CNT_MAX;
          rd_cnt[b]  <= CNT_MAX;
          rp_cnt[b]  <= '0;
        end
        else if (tick)
        begin
          if (is_act && hit)
          begin
            open[b]    <= 1'b1;
            ras_cnt[b] <= 8'h01;
          end
          else if (ras_cnt[b] != CNT_MAX) ras_cnt[b] <= ras_cnt[b] + 8'h01;
          if (is_rd && hit) rd_cnt[b] <= 8'h01;
          else if (rd_cnt[b] != CNT_MAX) rd_cnt[b] <= rd_cnt[b] + 8'h01;
          if (is_rda && hit)
          begin
            open[b]    <= 1'b0;
            ap_pend[b] <= 1'b1;
          end
          else if (is_act && hit) ap_pend[b] <= 1'b0;
          if (is_pre && hit)
          begin
            open[b]   <= 1'b0;
            rp_cnt[b] <= RP_CK - 8'h01;
          end
          else if (is_wra && hit)
          begin
            open[b]   <= 1'b0;
            rp_cnt[b] <= WRA_WAIT;
          end
          else if (is_rda && hit) rp_cnt[b] <= RDA_WAIT;
          else if (rp_cnt[b] != '0) rp_cnt[b] <= rp_cnt[b] - 8'h01;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cc_live <= 1'b0;
      cc_bank <= '0;
      cc_cnt  <= '0;
    end
    else if (tick)
    begin
      if (is_rda)
      begin
        cc_live <= 1'b1;
        cc_bank <= req_bank;
        cc_cnt  <= 8'h01;
      end
      else if (cc_cnt != CNT_MAX) cc_cnt <= cc_cnt + 8'h01;
    end
  end

  // write data goes out write_latency clocks after the command
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_sr    <= '0;
      wr_beats <= '0;
      wd       <= '0;
      wd_oe    <= 1'b0;
    end
    else if (tick)
    begin
      wr_sr <= {wr_sr[WR_LAT-2:0], is_wr};
      if (is_wr) wd <= req_wdata;
      if (wr_start) wr_beats <= CNT_W'(HALF_BL);
      else if (wr_beats != '0) wr_beats <= wr_beats - 8'h01;
      wd_oe <= wr_start || (wr_beats > 8'h01);
    end
  end

  // read data crosses from the link clock through two flops first
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_s1    <= '0;
      dq_s2    <= '0;
      stb_s1   <= 1'b0;
      stb_s2   <= 1'b0;
      oe_dly1  <= 1'b0;
      oe_dly2  <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end
    else
    begin
      dq_s1    <= link.dq;
      dq_s2    <= dq_s1;
      stb_s1   <= link.lower_byte_strobe;
      stb_s2   <= stb_s1;
      // own write strobes echo on the shared bus; delay the gate to line up with the two sync flops
      oe_dly1  <= wd_oe;
      oe_dly2  <= oe_dly1;
      rd_valid <= stb_s2 && !ck_q && !oe_dly2;
      if (stb_s2 && !ck_q) rd_data <= dq_s2;
    end
  end

  assign link.ck   = ck_q;
  assign link.cmd  = cmd_q;
  assign link.bank = bank_q;
  assign link.col  = col_q;
  assign link.auto_precharge_select_bit = ap_q;
  assign link.dq_c    = wd;
  assign link.dq_c_oe = wd_oe;
  assign link.lower_byte_strobe_c = wd_oe;
  assign link.upper_byte_strobe_c = wd_oe;
endmodule

// *** verilog/d2rp_dev.sv ***
// d2rp_dev: memory device end; per-bank auto precharge delay and data bursts
// assumes the controller keeps its own spacing; runs wholly on the link clock
`timescale 1ns/1ps
module d2rp_dev
  import d2rp_pkg::*;
(
  input  wire logic              rst_n,
  d2rp_link_if.dev               link,
  output logic [d2rp_pkg::BANKS-1:0] bank_open,
  output logic                   int_precharge
);
  import d2rp_pkg::*;

  localparam int PW = BANK_W + COL_W;
  logic [CNT_W-1:0]  ras_cnt [BANKS];
  logic [CNT_W-1:0]  rd_cnt [BANKS];
  logic [CNT_W-1:0]  rp_cnt [BANKS];
  logic [BANKS-1:0]  ap_pend;
  logic [BANKS-1:0]  fire;
  logic [DQ_W-1:0]   mem [BANKS];
  logic [PW-1:0]     rd_ad [RD_LAT];
  logic [PW-1:0]     wr_ad [WR_LAT];
  logic [RD_LAT-1:0] rd_sr;
  logic [WR_LAT-1:0] wr_sr;
  logic [CNT_W-1:0]  rd_beats;
  logic [CNT_W-1:0]  wr_beats;
  logic [CNT_W-1:0]  wr_left [BANKS];
  logic [BANK_W-1:0] wr_bank;
  logic [DQ_W-1:0]   dq_out;
  logic              dq_oe;

  wire is_act = (link.cmd == D2RP_ACT);
  wire is_rd  = (link.cmd == D2RP_RD);
  wire is_wr  = (link.cmd == D2RP_WR);
  wire is_pre = (link.cmd == D2RP_PRE);
  wire is_rda = is_rd && link.auto_precharge_select_bit;
  wire rd_go  = rd_sr[RD_LAT-1];
  wire wr_go  = wr_sr[WR_LAT-1];

  genvar b;
  generate
    for (b = 0; b < BANKS; b++)
    begin : g_bank
      wire hit = (link.bank == BANK_W'(b));
      // fires at AL+BL/2 or later when row-active, rtp or a write-ap burst is not yet done
      assign fire[b] = ap_pend[b] && (rd_cnt[b] >= AP_EDGE) && (ras_cnt[b] >= RAS_CK)
                       && (rd_cnt[b] >= RTP_DONE)
                       && (wr_left[b] == '0);
      always_ff @(posedge link.ck or negedge rst_n)
      begin
        if (!rst_n)
        begin
          bank_open[b] <= 1'b0;
          ap_pend[b]   <= 1'b0;
          ras_cnt[b]   <= CNT_MAX;
          rd_cnt[b]    <= CNT_MAX;
          rp_cnt[b]    <= '0;
          wr_left[b]   <= '0;
        end
        else
        begin
          if (is_act && hit)
          begin
            bank_open[b] <= 1'b1;
            ras_cnt[b]   <= 8'h01;
          end
          else if (ras_cnt[b] != CNT_MAX) ras_cnt[b] <= ras_cnt[b] + 8'h01;
          if (is_rd && hit) rd_cnt[b] <= 8'h01;
          else if (rd_cnt[b] != CNT_MAX) rd_cnt[b] <= rd_cnt[b] + 8'h01;
          if ((is_rda || (is_wr && link.auto_precharge_select_bit)) && hit)
            ap_pend[b] <= 1'b1;
          else if (fire[b]) ap_pend[b] <= 1'b0;
          // a write with auto precharge holds the row until its burst has gone by
          if (is_wr && link.auto_precharge_select_bit && hit) wr_left[b] <= CNT_W'(WR_LAT + HALF_BL);
          else if (wr_left[b] != '0) wr_left[b] <= wr_left[b] - 8'h01;
          // precharge period runs from the firing edge itself, not one edge later
          if (fire[b] || (is_pre && hit))
          begin
            bank_open[b] <= 1'b0;
            rp_cnt[b]    <= RP_CK;
          end
          else if (rp_cnt[b] != '0) rp_cnt[b] <= rp_cnt[b] - 8'h01;
        end
      end
    end
  endgenerate

  // write auto precharge reuses the read delay path; no separate write recovery model
  always_ff @(posedge link.ck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_sr         <= '0;
      wr_sr         <= '0;
      rd_beats      <= '0;
      wr_beats      <= '0;
      wr_bank       <= '0;
      dq_out        <= '0;
      dq_oe         <= 1'b0;
      int_precharge <= 1'b0;
    end
    else
    begin
      rd_sr <= {rd_sr[RD_LAT-2:0], is_rd};
      wr_sr <= {wr_sr[WR_LAT-2:0], is_wr};
      int_precharge <= |fire;
      if (rd_go)
      begin
        rd_beats <= CNT_W'(HALF_BL) - 8'h01;
        dq_out   <= mem[rd_ad[RD_LAT-1][PW-1:COL_W]] ^ DQ_W'(rd_ad[RD_LAT-1][COL_W-1:0]);
        dq_oe    <= 1'b1;
      end
      else if (rd_beats != '0)
      begin
        rd_beats <= rd_beats - 8'h01;
        dq_out   <= dq_out + 16'h0001;
      end
      else dq_oe <= 1'b0;
      if (wr_go)
      begin
        wr_beats <= CNT_W'(HALF_BL);
        wr_bank  <= wr_ad[WR_LAT-1][PW-1:COL_W];
      end
      else if (wr_beats != '0) wr_beats <= wr_beats - 8'h01;
    end
  end

  // address pipes and the small per-bank data store need no reset
  always_ff @(posedge link.ck)
  begin
    rd_ad[0] <= {link.bank, link.col};
    wr_ad[0] <= {link.bank, link.col};
    for (int i = 1; i < RD_LAT; i++) rd_ad[i] <= rd_ad[i-1];
    for (int i = 1; i < WR_LAT; i++) wr_ad[i] <= wr_ad[i-1];
    if (wr_beats != '0 && link.lower_byte_strobe) mem[wr_bank][7:0] <= link.dq[7:0];
    if (wr_beats != '0 && link.upper_byte_strobe) mem[wr_bank][15:8] <= link.dq[15:8];
  end

  assign link.dq_d = dq_out;
  assign link.dq_d_oe = dq_oe;
  assign link.lower_byte_strobe_d = dq_oe;
  assign link.upper_byte_strobe_d = dq_oe;
  assign link.strobe_d_oe = dq_oe;
endmodule

// *** verilog/d2rp_link_if.sv ***
// d2rp_link_if: command and data wires between controller and memory device
// the shared data bus level is resolved here from the two output enables
`timescale 1ns/1ps
interface d2rp_link_if;
  import d2rp_pkg::*;
  logic              ck;
  d2rp_cmd_type      cmd;
  logic [BANK_W-1:0] bank;
  logic [COL_W-1:0]  col;
  logic              auto_precharge_select_bit;
  logic [DQ_W-1:0]   dq_c;
  logic              dq_c_oe;
  logic [DQ_W-1:0]   dq_d;
  logic              dq_d_oe;
  logic              lower_byte_strobe_c;
  logic              upper_byte_strobe_c;
  logic              lower_byte_strobe_d;
  logic              upper_byte_strobe_d;
  logic              strobe_d_oe;
  wire  [DQ_W-1:0]   dq;
  wire               lower_byte_strobe;
  wire               upper_byte_strobe;
  // no pull model: an undriven bus reads as zero
  assign dq = dq_d_oe ? dq_d : (dq_c_oe ? dq_c : '0);
  assign lower_byte_strobe = strobe_d_oe ? lower_byte_strobe_d : (dq_c_oe & lower_byte_strobe_c);
  assign upper_byte_strobe = strobe_d_oe ? upper_byte_strobe_d : (dq_c_oe & upper_byte_strobe_c);
  modport ctrl (output ck, cmd, bank, col, auto_precharge_select_bit, dq_c, dq_c_oe,
                output lower_byte_strobe_c, upper_byte_strobe_c,
                input dq, lower_byte_strobe, upper_byte_strobe);
  modport dev (input ck, cmd, bank, col, auto_precharge_select_bit,
               output dq_d, dq_d_oe, lower_byte_strobe_d, upper_byte_strobe_d, strobe_d_oe,
               input dq, lower_byte_strobe, upper_byte_strobe);
endinterface

// *** verilog/d2rp_pkg.sv ***
// d2rp_pkg: shared constants and command codes for the read/precharge timing pair
// assumes both ends are built with the same latency and burst settings
package d2rp_pkg;
  localparam int BANKS  = 8;
  localparam int BANK_W = 3;
  localparam int COL_W  = 10;
  localparam int DQ_W   = 16;
  localparam int CNT_W  = 8;
  localparam int DIV_CYC = 1;
  localparam int CK_NS   = 16;
  localparam int ADD_LAT = 1;
  localparam int CAS_LAT = 3;
  localparam int BURST   = 4;
  localparam int HALF_BL = BURST / 2;
  localparam int RD_LAT  = ADD_LAT + CAS_LAT;
  localparam int WR_LAT  = RD_LAT - 1;
  localparam int RTP_NS  = 8;
  localparam int RP_NS   = 12;
  localparam int RAS_NS  = 40;
  localparam int RTP_CK0 = (RTP_NS + CK_NS - 1) / CK_NS;
  localparam int RTP_EFF = (RTP_CK0 > 2) ? RTP_CK0 : 2;
  localparam int RP_CKI  = (RP_NS + CK_NS - 1) / CK_NS;
  localparam int RAS_CKI = (RAS_NS + CK_NS - 1) / CK_NS;
  localparam int RTPRP_CKI = (RTP_NS + RP_NS + CK_NS - 1) / CK_NS;
  localparam int PF_OFS  = ADD_LAT + ((BURST == 8) ? 2 : 0);
  localparam logic [CNT_W-1:0] RP_CK     = CNT_W'(RP_CKI);
  localparam logic [CNT_W-1:0] RAS_CK    = CNT_W'(RAS_CKI);
  localparam logic [CNT_W-1:0] AP_EDGE   = CNT_W'(ADD_LAT + HALF_BL);
  localparam logic [CNT_W-1:0] RTP_DONE  = CNT_W'(PF_OFS + RTP_EFF);
  localparam logic [CNT_W-1:0] RD2PRE    = CNT_W'(ADD_LAT + HALF_BL - 2 + RTP_EFF);
  localparam logic [CNT_W-1:0] RDA2ACT   = CNT_W'(PF_OFS + RTPRP_CKI);
  localparam logic [CNT_W-1:0] CC_RD     = CNT_W'(HALF_BL);
  localparam logic [CNT_W-1:0] CC_WR     = CNT_W'(HALF_BL + 2);
  localparam logic [CNT_W-1:0] CC_PA     = 8'h01;
  localparam logic [CNT_W-1:0] CNT_MAX   = 8'hFF;
  typedef enum logic [2:0] {
    D2RP_NOP = 3'h0,
    D2RP_ACT = 3'h1,
    D2RP_RD  = 3'h2,
    D2RP_WR  = 3'h3,
    D2RP_PRE = 3'h4
  } d2rp_cmd_type;
endpackage
